// >>> design/meter_pkg.sv
/*
  constants, command and answer carriers, states and error codes for the
  gated frequency / period meter.
  assumes a 50 MHz clock and a host that issues one command at a time.
*/
// Function
// - frequency mode: counter 2 gives a continuous 1 ms tick
// - counter 1 gates for the requested ms, 10 to 32767
// - counter 0 held at 65535 while waiting for the gate to open
// - counter 0 counts unknown-signal edges only while the gate is high
// - on gate fall the counts decremented from preload are reported
// - frequency equals count times 1000 divided by gate ms
// - a frequency run is given at most four gate intervals
// - period mode: counter 2 counts from rising to next falling edge
// - longest high time is 65.54 ms, the full 16-bit range
// - period mode leaves counters 0 and 1 untouched
// - counts are 16-bit up to 65535, negative if read signed
// - before a channel change gain goes to unity, then requested code
// - conversion takes point 0-127, gain 0 or 8-15; returns counts, gain
// - end-of-conversion never toggling gives error 3
// - point list holds 128 entries; adding to a full list gives error 4
// - counter number other than 0, 1, 2 gives error 8
// - counter mode above 5 gives error 9
// - second interrupt setup without reset gives error 10
// - interrupt line outside 2 to 7 gives error 11
// - conversion count above 32767 gives error 16
// - base address outside 100h to 3F8h gives error 2
package meter_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int TICK_US        = 1000;     // gate time base, 1 ms
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int PER_TICK_NS    = 1000;     // period resolution, 1 us
  localparam int PER_CYCLES     = CLK_HZ / 1_000_000 * PER_TICK_NS / 1000;
  localparam int CONV_MAX_NS    = 35_000;   // longest converter time
  localparam int CONV_CYCLES    = CLK_HZ / 1_000_000 * CONV_MAX_NS / 1000;
  localparam int RUN_FACTOR     = 4;        // gate intervals per run
  localparam int PER_LIMIT_MS   = 4 * 66;   // period run watchdog

  // ----------------------------------------------------------------------
  // limits and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE  = 16'hFFFF;
  localparam logic [15:0] GATE_MIN    = 16'h000A;
  localparam logic [15:0] GATE_MAX    = 16'h7FFF;
  localparam logic [15:0] CONV_MAX    = 16'h7FFF;
  localparam logic [15:0] BASE_MIN    = 16'h0100;
  localparam logic [15:0] BASE_MAX    = 16'h03F8;
  localparam logic [15:0] POINT_MAX   = 16'h007F;
  localparam logic [15:0] MODE_MAX    = 16'h0005;
  localparam logic [15:0] CTR_MAX     = 16'h0002;
  localparam logic [15:0] IRQ_MIN     = 16'h0002;
  localparam logic [15:0] IRQ_MAX     = 16'h0007;
  localparam logic [9:0]  FREQ_SCALE  = 10'h3E8;   // 1000
  localparam logic [3:0]  GAIN_UNITY  = 4'h0;
  localparam int          LIST_DEPTH  = 128;

  localparam logic [4:0] ERR_NONE     = 5'h00;
  localparam logic [4:0] ERR_BASE     = 5'h02;
  localparam logic [4:0] ERR_CONV     = 5'h03;
  localparam logic [4:0] ERR_LIST     = 5'h04;
  localparam logic [4:0] ERR_POINT    = 5'h05;
  localparam logic [4:0] ERR_GAIN     = 5'h06;
  localparam logic [4:0] ERR_CTR      = 5'h08;
  localparam logic [4:0] ERR_MODE     = 5'h09;
  localparam logic [4:0] ERR_IRQ_SET  = 5'h0A;
  localparam logic [4:0] ERR_IRQ_NUM  = 5'h0B;
  localparam logic [4:0] ERR_NCONV    = 5'h10;
  localparam logic [4:0] ERR_TIMEOUT  = 5'h12;
  localparam logic [4:0] ERR_INTERVAL = 5'h13;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_FREQ, OP_PERIOD, OP_LOAD_CTR, OP_READ_CTR, OP_CONVERT,
    OP_LIST_ADD, OP_LIST_CLEAR, OP_IRQ_SETUP, OP_IRQ_RESET,
    OP_SET_NCONV, OP_SET_BASE
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [15:0] arg0;
    logic [15:0] arg1;
    logic [15:0] arg2;
  } cmd_t;

  typedef struct packed {
    logic [4:0]  err;
    logic [15:0] data0;
    logic [15:0] data1;
    logic [31:0] freq;
  } rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FREQ_LOW, ST_FREQ_GATE, ST_DIV, ST_PER_LOW, ST_PER_WAIT,
    ST_PER_HIGH, ST_CONV_UNITY, ST_CONV_GAIN, ST_CONV_WAIT, ST_DONE
  } st_t;

endpackage : meter_pkg

// >>> design/gated_freq_period_meter.sv
/*
  gated frequency / period meter with three 16-bit counters, parameter
  checks, a point list and an ordered gain / channel sequence.
  assumes sig_in, gate_sense_input, eoc_in and adc_data are asynchronous
  and the host waits for cmd_ready before each command.
*/
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// two flip-flop synchroniser
// ------------------------------------------------------------------------
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2

// ------------------------------------------------------------------------
// meter top
// ------------------------------------------------------------------------
module gated_freq_period_meter #(
  parameter logic [15:0] TICK_LOAD = 16'(meter_pkg::TICK_CYCLES - 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             cmd_valid,
  input  wire meter_pkg::cmd_t  cmd,
  output logic                  cmd_ready,
  output logic                  rsp_valid,
  output meter_pkg::rsp_t       rsp_r,
  input  wire logic             sig_in,
  input  wire logic             gate_sense_input,
  input  wire logic             eoc_in,
  input  wire logic [11:0]      adc_data,
  output logic                  tick_r,
  output logic                  gate_r,
  output logic [3:0]            gain_r,
  output logic [2:0]            chan_r,
  output logic [3:0]            submux_r,
  output logic                  conv_start_r,
  output logic                  irq_armed_r,
  output logic [2:0]            irq_line_r,
  output logic [15:0]           nconv_r,
  output logic [15:0]           base_r,
  output logic [4:0]            last_err_r
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  meter_pkg::st_t   st_r;
  logic [15:0]      ctr_r [3];
  logic [2:0]       mode_r [3];
  logic [3:0]       list_r [meter_pkg::LIST_DEPTH];
  logic [7:0]       list_cnt_r;
  logic [15:0]      gate_ms_r;
  logic [18:0]      wd_r;
  logic [5:0]       us_r;
  logic [15:0]      conv_wait_r;
  logic             eoc_start_r;
  logic             sig_d_r;
  logic             per_d_r;
  logic [25:0]      dvd_r;
  logic [15:0]      rem_r;
  logic [4:0]       bit_r;
  logic [15:0]      count_r;
  logic [2:0]       point_r;

  logic             sig_s;
  logic             per_s;
  logic             eoc_s;
  logic [11:0]      adc_s;

  sync2 #(.WIDTH(1)) u_sig (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (sig_in),
    .q     (sig_s)
  );

  sync2 #(.WIDTH(1)) u_per (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (gate_sense_input),
    .q     (per_s)
  );

  sync2 #(.WIDTH(13)) u_adc (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({eoc_in, adc_data}),
    .q     ({eoc_s, adc_s})
  );

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire        take       = cmd_valid && cmd_ready;
  wire [1:0]  sel        = cmd.arg0[1:0];
  wire        sel_bad    = cmd.arg0 > meter_pkg::CTR_MAX;
  wire        mode_bad   = cmd.arg1 > meter_pkg::MODE_MAX;
  wire        point_bad  = cmd.arg0 > meter_pkg::POINT_MAX;
  wire        gain_ok    = (cmd.arg1 == 16'h0000) ||
                           (cmd.arg1[15:4] == 12'h000 && cmd.arg1[3]);
  wire        irq_bad    = (cmd.arg0 < meter_pkg::IRQ_MIN) ||
                           (cmd.arg0 > meter_pkg::IRQ_MAX);
  wire        gate_bad   = (cmd.arg0 < meter_pkg::GATE_MIN) ||
                           (cmd.arg0 > meter_pkg::GATE_MAX);
  wire        base_bad   = (cmd.arg0 < meter_pkg::BASE_MIN) ||
                           (cmd.arg0 > meter_pkg::BASE_MAX);
  wire        list_full  = list_cnt_r == 8'(meter_pkg::LIST_DEPTH);
  wire        sig_rise   = sig_s && !sig_d_r;
  wire        per_rise   = per_s && !per_d_r;
  wire        per_fall   = !per_s && per_d_r;
  wire        tick_now   = ctr_r[2] == 16'h0000;
  wire        us_now     = us_r == 6'(meter_pkg::PER_CYCLES - 1);
  wire [18:0] run_limit  = 19'(gate_ms_r) * 19'(meter_pkg::RUN_FACTOR);
  wire [16:0] trial      = {rem_r, dvd_r[25]};
  wire        trial_ge   = trial >= 17'(gate_ms_r);
  wire [3:0]  list_gain  = (cmd.arg0[7:0] < list_cnt_r) ?
                           list_r[cmd.arg0[6:0]] : 4'h0;

  assign cmd_ready = st_r == meter_pkg::ST_IDLE;
  assign rsp_valid = st_r == meter_pkg::ST_DONE;

  // ----------------------------------------------------------------------
  // point list storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (take && cmd.op == meter_pkg::OP_LIST_ADD && !list_full)
      list_r[list_cnt_r[6:0]] <= cmd.arg0[3:0];
  end

  // ----------------------------------------------------------------------
  // input edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sig_d_r <= 1'b0;
      per_d_r <= 1'b0;
    end
    else
    begin
      sig_d_r <= sig_s;
      per_d_r <= per_s;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r         <= meter_pkg::ST_IDLE;
      ctr_r        <= '{default: 16'h0000};
      mode_r       <= '{default: 3'h0};
      list_cnt_r   <= 8'h00;
      gate_ms_r    <= 16'h0000;
      wd_r         <= 19'h00000;
      us_r         <= 6'h00;
      conv_wait_r  <= 16'h0000;
      eoc_start_r  <= 1'b0;
      dvd_r        <= 26'h0000000;
      rem_r        <= 16'h0000;
      bit_r        <= 5'h00;
      count_r      <= 16'h0000;
      point_r      <= 3'h0;
      rsp_r        <= '0;
      tick_r       <= 1'b0;
      gate_r       <= 1'b0;
      gain_r       <= meter_pkg::GAIN_UNITY;
      chan_r       <= 3'h0;
      submux_r     <= 4'h0;
      conv_start_r <= 1'b0;
      irq_armed_r  <= 1'b0;
      irq_line_r   <= 3'h0;
      nconv_r      <= 16'h0000;
      base_r       <= 16'h0000;
      last_err_r   <= meter_pkg::ERR_NONE;
    end
    else
    begin
      tick_r       <= 1'b0;
      conv_start_r <= 1'b0;
      unique case (st_r)
        meter_pkg::ST_IDLE:
        begin
          rsp_r <= '0;
          if (take)
          begin
            st_r <= meter_pkg::ST_DONE;
            unique case (cmd.op)
              meter_pkg::OP_FREQ:
                if (gate_bad) rsp_r.err <= meter_pkg::ERR_INTERVAL;
                else
                begin
                  gate_ms_r <= cmd.arg0;
                  ctr_r[2]  <= TICK_LOAD;
                  ctr_r[0]  <= meter_pkg::FULL_SCALE;
                  wd_r      <= 19'h00000;
                  st_r      <= meter_pkg::ST_FREQ_LOW;
                end
              meter_pkg::OP_PERIOD:
              begin
                ctr_r[2] <= meter_pkg::FULL_SCALE;
                us_r     <= 6'h00;
                wd_r     <= 19'h00000;
                st_r     <= meter_pkg::ST_PER_LOW;
              end
              meter_pkg::OP_LOAD_CTR:
                if (sel_bad) rsp_r.err <= meter_pkg::ERR_CTR;
                else if (mode_bad)
                  rsp_r.err <= meter_pkg::ERR_MODE;
                else
                begin
                  ctr_r[sel]  <= cmd.arg2;
                  mode_r[sel] <= cmd.arg1[2:0];
                end
              meter_pkg::OP_READ_CTR:
                if (sel_bad) rsp_r.err <= meter_pkg::ERR_CTR;
                else rsp_r.data0 <= ctr_r[sel];
              meter_pkg::OP_CONVERT:
                if (point_bad) rsp_r.err <= meter_pkg::ERR_POINT;
                else if (!gain_ok)
                  rsp_r.err <= meter_pkg::ERR_GAIN;
                else
                begin
                  gain_r        <= meter_pkg::GAIN_UNITY;
                  count_r       <= cmd.arg1;
                  point_r       <= cmd.arg0[2:0];
                  rsp_r.data1   <= 16'(list_gain);
                  submux_r      <= list_gain;
                  st_r          <= meter_pkg::ST_CONV_UNITY;
                end
              meter_pkg::OP_LIST_ADD:
                if (list_full) rsp_r.err <= meter_pkg::ERR_LIST;
                else list_cnt_r <= list_cnt_r + 8'h01;
              meter_pkg::OP_LIST_CLEAR:
                list_cnt_r <= 8'h00;
              meter_pkg::OP_IRQ_SETUP:
                if (irq_armed_r)
                  rsp_r.err <= meter_pkg::ERR_IRQ_SET;
                else if (irq_bad)
                  rsp_r.err <= meter_pkg::ERR_IRQ_NUM;
                else
                begin
                  irq_armed_r <= 1'b1;
                  irq_line_r  <= cmd.arg0[2:0];
                end
              meter_pkg::OP_IRQ_RESET:
                irq_armed_r <= 1'b0;
              meter_pkg::OP_SET_NCONV:
                if (cmd.arg0 > meter_pkg::CONV_MAX)
                  rsp_r.err <= meter_pkg::ERR_NCONV;
                else nconv_r <= cmd.arg0;
              meter_pkg::OP_SET_BASE:
                if (base_bad) rsp_r.err <= meter_pkg::ERR_BASE;
                else base_r <= cmd.arg0;
              default:
                rsp_r.err <= meter_pkg::ERR_CTR;
            endcase
          end
        end

        // gate low: preload held, wait for a tick to align the gate
        meter_pkg::ST_FREQ_LOW:
        begin
          ctr_r[0] <= meter_pkg::FULL_SCALE;
          if (tick_now)
          begin
            gate_r   <= 1'b1;
            ctr_r[1] <= gate_ms_r;
            st_r     <= meter_pkg::ST_FREQ_GATE;
          end
        end

        // gate high: count unknown edges, count down the gate in ms
        meter_pkg::ST_FREQ_GATE:
        begin
          if (sig_rise)
            ctr_r[0] <= ctr_r[0] - 16'h0001;
          if (tick_now)
          begin
            ctr_r[1] <= ctr_r[1] - 16'h0001;
            if (ctr_r[1] == 16'h0001)
            begin
              gate_r  <= 1'b0;
              count_r <= meter_pkg::FULL_SCALE - ctr_r[0];
              st_r    <= meter_pkg::ST_DIV;
              bit_r   <= 5'h00;
              rem_r   <= 16'h0000;
            end
          end
        end

        // restoring divide: count * 1000 / gate ms
        meter_pkg::ST_DIV:
        begin
          if (bit_r == 5'h00)
            dvd_r <= 26'(count_r) * 26'(meter_pkg::FREQ_SCALE);
          else
          begin
            rem_r <= trial_ge ? 16'(trial - 17'(gate_ms_r))
                              : trial[15:0];
            dvd_r <= {dvd_r[24:0], trial_ge};
          end
          bit_r <= bit_r + 5'h01;
          if (bit_r == 5'h1A)
          begin
            rsp_r.data0 <= count_r;
            rsp_r.freq  <= {6'h00, dvd_r[24:0], trial_ge};
            st_r        <= meter_pkg::ST_DONE;
          end
        end

        // period: wait for input low, then for its rising edge
        meter_pkg::ST_PER_LOW:
          if (!per_s) st_r <= meter_pkg::ST_PER_WAIT;
        meter_pkg::ST_PER_WAIT:
          if (per_rise)
          begin
            us_r <= 6'h00;
            st_r <= meter_pkg::ST_PER_HIGH;
          end

        // high time counted in us on counter 2 only
        meter_pkg::ST_PER_HIGH:
        begin
          if (us_now && ctr_r[2] != 16'h0000)
            ctr_r[2] <= ctr_r[2] - 16'h0001;
          if (per_fall)
          begin
            rsp_r.data0 <= meter_pkg::FULL_SCALE - ctr_r[2];
            st_r        <= meter_pkg::ST_DONE;
          end
        end

        // unity gain stands while the channel changes
        meter_pkg::ST_CONV_UNITY:
        begin
          chan_r <= point_r;
          st_r   <= meter_pkg::ST_CONV_GAIN;
        end
        meter_pkg::ST_CONV_GAIN:
        begin
          gain_r       <= count_r[3:0];
          conv_start_r <= 1'b1;
          eoc_start_r  <= eoc_s;
          conv_wait_r  <= 16'h0000;
          st_r         <= meter_pkg::ST_CONV_WAIT;
        end
        meter_pkg::ST_CONV_WAIT:
        begin
          conv_wait_r <= conv_wait_r + 16'h0001;
          if (eoc_s != eoc_start_r)
          begin
            rsp_r.data0 <= {4'h0, adc_s};
            st_r        <= meter_pkg::ST_DONE;
          end
          else if (conv_wait_r == 16'(meter_pkg::CONV_CYCLES))
          begin
            rsp_r.err <= meter_pkg::ERR_CONV;
            st_r      <= meter_pkg::ST_DONE;
          end
        end

        meter_pkg::ST_DONE:
        begin
          last_err_r <= rsp_r.err;
          st_r       <= meter_pkg::ST_IDLE;
        end
        default:
          st_r <= meter_pkg::ST_IDLE;
      endcase

      // counter 2 as 1 ms time base and the run watchdogs
      if (st_r == meter_pkg::ST_FREQ_LOW ||
          st_r == meter_pkg::ST_FREQ_GATE)
      begin
        ctr_r[2] <= tick_now ? TICK_LOAD : ctr_r[2] - 16'h0001;
        tick_r   <= tick_now;
        if (tick_now)
          wd_r <= wd_r + 19'h00001;
        if (tick_now && wd_r + 19'h00001 >= run_limit)
        begin
          gate_r    <= 1'b0;
          rsp_r.err <= meter_pkg::ERR_TIMEOUT;
          st_r      <= meter_pkg::ST_DONE;
        end
      end
      else if (st_r == meter_pkg::ST_PER_LOW ||
               st_r == meter_pkg::ST_PER_WAIT ||
               st_r == meter_pkg::ST_PER_HIGH)
      begin
        us_r <= us_now ? 6'h00 : us_r + 6'h01;
        if (us_now)
          wd_r <= wd_r + 19'h00001;
        if (wd_r == 19'(meter_pkg::PER_LIMIT_MS * 1000))
        begin
          rsp_r.err <= meter_pkg::ERR_TIMEOUT;
          st_r      <= meter_pkg::ST_DONE;
        end
      end
    end
  end

endmodule : gated_freq_period_meter

// >>> tb/meter_chk.sv
/* checker for the meter command port and gain sequencing.
   assumes it is bound by name onto the meter top. */
`timescale 1ns/10ps
module meter_chk #(
  parameter logic [15:0] TICK_LOAD = 16'h0031
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            cmd_valid,
  input wire meter_pkg::cmd_t cmd,
  input wire logic            cmd_ready,
  input wire logic            rsp_valid,
  input wire meter_pkg::rsp_t rsp_r,
  input wire logic [3:0]      gain_r,
  input wire logic [2:0]      chan_r,
  input wire logic            irq_armed_r,
  input wire logic [4:0]      last_err_r
);
  // taken commands by kind
  wire tk = cmd_valid && cmd_ready;
  wire lc = tk && cmd.op == meter_pkg::OP_LOAD_CTR;
  wire ir = tk && cmd.op == meter_pkg::OP_IRQ_SETUP;
  wire nc = tk && cmd.op == meter_pkg::OP_SET_NCONV;
  wire ba = tk && cmd.op == meter_pkg::OP_SET_BASE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // answer carrying a given code
  sequence s_err(logic [4:0] e);
    rsp_valid && rsp_r.err == e;
  endsequence
  a_ctr_number: assert property (
    lc && cmd.arg0 > 16'h0002 |=> s_err(meter_pkg::ERR_CTR))
    else $error("counter number not refused");
  a_mode_range: assert property (
    lc && cmd.arg0 <= 16'h0002 && cmd.arg1 > 16'h0005
    |=> s_err(meter_pkg::ERR_MODE)) else $error("mode not refused");
  a_irq_twice: assert property (
    ir && irq_armed_r |=> s_err(meter_pkg::ERR_IRQ_SET))
    else $error("second setup not refused");
  a_irq_line: assert property (
    ir && !irq_armed_r && (cmd.arg0 < 16'h0002 || cmd.arg0 > 16'h0007)
    |=> s_err(meter_pkg::ERR_IRQ_NUM)) else $error("line not refused");
  a_nconv_max: assert property (
    nc && cmd.arg0 > 16'h7FFF |=> s_err(meter_pkg::ERR_NCONV))
    else $error("count not refused");
  a_base_range: assert property (
    ba && (cmd.arg0 < 16'h0100 || cmd.arg0 > 16'h03F8)
    |=> s_err(meter_pkg::ERR_BASE)) else $error("base not refused");
  a_err_held: assert property (
    rsp_valid |=> !rsp_valid && last_err_r == $past(rsp_r.err))
    else $error("last error not held");
  a_chan_unity: assert property (
    $changed(chan_r) |-> gain_r == meter_pkg::GAIN_UNITY)
    else $error("channel changed at high gain");
endmodule : meter_chk

bind gated_freq_period_meter meter_chk #(.TICK_LOAD(TICK_LOAD)) u_chk (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_r(rsp_r),
  .gain_r(gain_r), .chan_r(chan_r), .irq_armed_r(irq_armed_r),
  .last_err_r(last_err_r));

// >>> tb/meter_far_end.sv
/* far end: unknown signal source and converter.
   assumes the meter pulses start for one cycle per conversion. */
`timescale 1ns/10ps
module meter_far_end #(
  parameter logic [11:0] ADC_VAL = 12'h5A3
) (
  input wire logic        clk,
  input wire logic        start,
  input wire logic        mute,
  input wire logic [7:0]  half,
  output logic            sig,
  output logic            eoc,
  output logic [11:0]     adc
);
  logic [7:0] ph = 8'h00;
  logic [5:0] cnt = 6'h00;
  logic [3:0] h = 4'h0;
  initial sig = 1'b0;
  initial eoc = 1'b0;
  // data valid only around the toggle, inverted elsewhere
  assign adc = (h != 4'h0) ? ADC_VAL : ~ADC_VAL;
  // signal divider, conversion countdown, end toggle
  always @(posedge clk)
  begin
    ph <= (ph + 8'h01 >= half) ? 8'h00 : ph + 8'h01;
    if (half != 8'h00 && ph + 8'h01 >= half) sig <= ~sig;
    cnt <= (start && !mute) ? 6'h28 : cnt - 6'(cnt != 6'h00);
    h <= (cnt == 6'h03) ? 4'hF : h - 4'(h != 4'h0);
    if (cnt == 6'h01) eoc <= ~eoc;
  end
endmodule : meter_far_end

// >>> tb/gated_freq_period_meter_tb.sv
/* bench: refusals, random loads, list, conversions, frequency, period.
   assumes the far-end model and the bound checker. */
`timescale 1ns/10ps
module gated_freq_period_meter_tb;
  typedef struct {logic [4:0] e; int d0, tol, ivl, d1;} note_t;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            cmd_valid = 1'b0;
  meter_pkg::cmd_t cmd = '0;
  logic            gsi = 1'b0;
  logic            mute = 1'b0;
  logic [7:0]      half = 8'h00;
  logic            cmd_ready, rsp_valid, sig, eoc, cst;
  meter_pkg::rsp_t rsp_r;
  logic [11:0]     adc;
  logic [3:0]      gain_r;
  logic [2:0]      chan_r;
  logic [4:0]      last_err_r;
  logic            tick, gate;
  logic [15:0]     ncv, bas;
  int              tks = 0, gcyc = 0;
  note_t           exp_q[$];
  note_t           n;
  int              n_errors = 0, checks = 0, cyc = 0, wait_n, i, a, b;

  always #10 clk = ~clk;

  // ticks and gate cycles, sampled away from the launching edge
  always @(negedge clk)
  begin
    tks  += tick;
    gcyc += gate;
  end

  gated_freq_period_meter #(.TICK_LOAD(16'h0031)) u_dut (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_r(rsp_r),
    .sig_in(sig), .gate_sense_input(gsi), .eoc_in(eoc),
    .adc_data(adc), .tick_r(tick), .gate_r(gate), .gain_r(gain_r),
    .chan_r(chan_r), .submux_r(), .conv_start_r(cst), .irq_armed_r(),
    .irq_line_r(), .nconv_r(ncv), .base_r(bas), .last_err_r(last_err_r));
  meter_far_end u_far (.clk(clk), .start(cst), .mute(mute),
    .half(half), .sig(sig), .eoc(eoc), .adc(adc));

  task automatic check(input logic [31:0] seen, exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, m, seen, exp);
    end
  endtask : check

  function automatic note_t nt(logic [4:0] e, int d0 = -1, tol = 0,
      ivl = 0, d1 = -1);
    return '{e, d0, tol, ivl, d1};
  endfunction : nt

  // one command, held until taken, then wait for idle
  task automatic send(input meter_pkg::op_t op,
      input logic [15:0] a0, a1, a2, input note_t nn);
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd = '{op, a0, a1, a2};
    exp_q.push_back(nn);
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    for (wait_n = 0; cmd_ready !== 1'b1; wait_n++) @(posedge clk) #1;
  endtask : send

  task automatic go(input meter_pkg::op_t op, input logic [15:0] a0,
      a1, input logic [4:0] e);
    send(op, a0, a1, '0, nt(e));
  endtask : go

  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // answers matched in order against the notes
  always @(negedge clk)
    if (rst_n === 1'b1 && rsp_valid === 1'b1)
    begin
      n = exp_q.pop_front();
      check(32'(rsp_r.err), 32'(n.e), "err");
      if (n.d0 >= 0) check(32'(rsp_r.data0 + n.tol >= n.d0 &&
        rsp_r.data0 <= n.d0 + n.tol), 32'h1, "count");
      if (n.d1 >= 0) check(32'(rsp_r.data1), n.d1, "gain");
      if (n.ivl > 0) check(rsp_r.freq,
        rsp_r.data0 * 32'h3E8 / n.ivl, "freq");
    end

  // hang guard
  always @(posedge clk)
    if (++cyc == 32'h4E20)
    begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end

  initial
  begin
    void'($urandom(32'h777FAC6E));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check(32'(last_err_r), '0, "err at reset");
    check(32'(gain_r), '0, "gain at reset");
    go(meter_pkg::OP_LOAD_CTR, 16'h0003, '0, 5'h08);
    go(meter_pkg::OP_LOAD_CTR, 16'h0002, 16'h0006, 5'h09);
    go(meter_pkg::OP_IRQ_SETUP, 16'h0008, '0, 5'h0B);
    go(meter_pkg::OP_IRQ_SETUP, 16'h0007, '0, 5'h00);
    go(meter_pkg::OP_IRQ_SETUP, 16'h0002, '0, 5'h0A);
    go(meter_pkg::OP_SET_NCONV, 16'h8000, '0, 5'h10);
    go(meter_pkg::OP_SET_NCONV, 16'h7FFF, '0, 5'h00);
    go(meter_pkg::OP_SET_BASE, 16'h03F9, '0, 5'h02);
    go(meter_pkg::OP_SET_BASE, 16'h0100, '0, 5'h00);
    check(32'(ncv), 32'h7FFF, "nconv");
    check(32'(bas), 32'h100, "base");
    go(meter_pkg::OP_FREQ, 16'h0009, '0, 5'h13);
    // random counter loads
    repeat (6)
    begin
      a = $urandom % 4;
      b = $urandom % 8;
      send(meter_pkg::OP_LOAD_CTR, 16'(a), 16'(b), 16'($urandom),
        nt(a > 2 ? 5'h08 : b > 5 ? 5'h09 : 5'h00));
    end
    // list filled to its limit
    go(meter_pkg::OP_LIST_CLEAR, '0, '0, 5'h00);
    for (i = 0; i < meter_pkg::LIST_DEPTH; i++)
      go(meter_pkg::OP_LIST_ADD, 16'((i + 5) % 16), '0, 5'h00);
    go(meter_pkg::OP_LIST_ADD, '0, '0, 5'h04);
    // conversions: refusals, lookup, gain order, dead converter
    go(meter_pkg::OP_CONVERT, 16'h0080, '0, 5'h05);
    go(meter_pkg::OP_CONVERT, '0, 16'h0007, 5'h06);
    send(meter_pkg::OP_CONVERT, 16'h0009, '0, '0,
      nt(5'h00, 32'h5A3, 0, 0, 32'hE));
    send(meter_pkg::OP_CONVERT, '0, 16'h0009, '0,
      nt(5'h00, 32'h5A3, 0, 0, 32'h5));
    check(32'(gain_r), 32'h9, "gain after");
    mute = 1'b1;
    go(meter_pkg::OP_CONVERT, '0, 16'h0008, 5'h03);
    mute = 1'b0;
    // 10-tick gate, 10 us at this TICK_LOAD: 50 edges, then a still input
    half = 8'h05;
    send(meter_pkg::OP_FREQ, 16'h000A, '0, '0,
      nt(5'h00, 32'h32, 1, 32'hA));
    check(32'(wait_n <= 32'h7D0), 32'h1, "run time");
    check(tks, 32'hB, "ticks");
    check(gcyc, 32'h1F4, "gate");
    half = 8'h00;
    send(meter_pkg::OP_FREQ, 16'h000A, '0, '0,
      nt(5'h00, 0, 0, 32'hA));
    // 2000-cycle high pulse is 40 us
    fork
      send(meter_pkg::OP_PERIOD, '0, '0, '0,
        nt(5'h00, 32'h28, 1));
      begin
        repeat (20) @(posedge clk);
        #1 gsi = 1'b1;
        repeat (2000) @(posedge clk);
        #1 gsi = 1'b0;
      end
    join
    send(meter_pkg::OP_READ_CTR, '0, '0, '0,
      nt(5'h00, 32'hFFFF));
    check(exp_q.size(), '0, "answers");
    tally_and_finish();
  end
endmodule : gated_freq_period_meter_tb
